// file: rtl/fpe_pkg.sv
package fpe_pkg;

   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int          ADDR_W       = 14;
   localparam int          NUM_BANKS    = 4;
   localparam int          BANK_BYTES   = 4096;
   localparam int          WL_BYTES     = 32;
   localparam int          NUM_WL       = NUM_BANKS * BANK_BYTES / WL_BYTES;
   localparam int          ECC_W        = 12;
   localparam logic [1:0]  DATA_BANK    = 2'h0;
   localparam logic [4:0]  WL_LAST_BYTE = 5'h1F;

   // code bank sector limits (offset within bank)
   localparam logic [11:0] CB_S1_BASE   = 12'hF00;
   localparam logic [11:0] CB_S2_BASE   = 12'hF80;
   // data bank sector limits, sectors 1..9
   localparam logic [11:0] DB_S1_BASE   = 12'h400;
   localparam logic [11:0] DB_S2_BASE   = 12'h800;
   localparam logic [11:0] DB_S3_BASE   = 12'hA00;
   localparam logic [11:0] DB_S4_BASE   = 12'hC00;
   localparam logic [11:0] DB_S5_BASE   = 12'hD00;
   localparam logic [11:0] DB_S6_BASE   = 12'hE00;
   localparam logic [11:0] DB_S7_BASE   = 12'hE80;
   localparam logic [11:0] DB_S8_BASE   = 12'hF00;
   localparam logic [11:0] DB_S9_BASE   = 12'hF80;
   localparam int          NUM_SECT     = 10;

   // how often a wordline may be programmed before erase
   localparam logic [1:0]  CB_PROG_MAX  = 2'h1;
   localparam logic [1:0]  DB_PROG_MAX  = 2'h2;

   // ----------------------------------------------------------------
   // timing, core_clk at 100 MHz
   // ----------------------------------------------------------------
   localparam int          PROG_CYCLES_DEF  = 209440;
   localparam int          ERASE_CYCLES_DEF = 8175360;
   localparam int          CPU_CLK_DIV      = 3;
   localparam int          READ_CPU_PERIODS = 3;
   localparam int          READ_CYCLES      = READ_CPU_PERIODS * CPU_CLK_DIV;
   localparam int          TIMER_W          = 24;
   localparam int          RCNT_W           = 4;

   typedef enum logic [1:0] {
      FPE_OP_PROG  = 2'b01,
      FPE_OP_ERASE = 2'b10
   } fpe_op_t;

   typedef enum logic [1:0] {
      FPE_ST_IDLE  = 2'b00,
      FPE_ST_LOAD  = 2'b01,
      FPE_ST_PROG  = 2'b10,
      FPE_ST_ERASE = 2'b11
   } fpe_state_t;

   typedef struct packed {
      fpe_op_t                op;
      logic [ADDR_W-1:0]      addr;
      logic [NUM_SECT-1:0]    sect_mask;
   } fpe_cmd_t;

   typedef struct packed {
      logic                   busy;
      logic                   done;
      logic                   aborted;
      logic                   reject;
      logic                   rd_valid;
      logic                   corrected;
      logic                   nmi_mem;
      logic                   nmi_ecc;
      logic [7:0]             rd_data;
   } fpe_stat_t;

endpackage

// file: rtl/fpe_ctrl.sv
`timescale 1ns/1ns
module fpe_ctrl #(
   parameter int unsigned PROG_CYCLES  = fpe_pkg::PROG_CYCLES_DEF,
   parameter int unsigned ERASE_CYCLES = fpe_pkg::ERASE_CYCLES_DEF
) (
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   input  wire logic                    cmd_valid,
   input  wire fpe_pkg::fpe_cmd_t       cmd,
   input  wire logic                    ld_valid,
   input  wire logic [7:0]              ld_data,
   input  wire logic                    abort_req,
   input  wire logic                    rd_req,
   input  wire logic [fpe_pkg::ADDR_W-1:0] rd_addr,
   input  wire logic                    memory_event_nmi_enable,
   input  wire logic                    correction_event_nmi_enable,
   output fpe_pkg::fpe_stat_t           stat
);
   import fpe_pkg::*;
   localparam int RD_LAT = READ_CYCLES;

   typedef struct packed {
      fpe_state_t              st;
      logic [ADDR_W-6:0]       wl;
      logic [1:0]              bank;
      logic [NUM_SECT-1:0]     mask;
      logic [5:0]              ld_idx;
      logic [TIMER_W-1:0]      timer;
      logic                    rd_busy;
      logic [RCNT_W-1:0]       rd_cnt;
      logic [ECC_W-1:0]        rd_word;
      fpe_stat_t               out;
   } fpe_regs_t;

   fpe_regs_t             s_r;
   fpe_regs_t             s_nxt;
   logic [ECC_W-1:0]      mem      [NUM_BANKS*BANK_BYTES] = '{default: '0};
   logic [1:0]            wl_cnt   [NUM_WL] = '{default: '0};  // non-volatile: no reset, starts erased
   logic [7:0]            wl_buf   [WL_BYTES];
   logic                  mem_we;
   logic [ADDR_W-1:0]     mem_wa;
   logic [ECC_W-1:0]      mem_wd;
   logic                  cnt_we;
   logic [1:0]            cnt_wd;
   logic [ADDR_W-6:0]     cnt_wa;

   // ----------------------------------------------------------------
   // ecc and sector decoding
   // ----------------------------------------------------------------
   // hamming(12,8): all-zero data encodes to all-zero code, so erased = 0
   function automatic logic [ECC_W-1:0] ecc_enc(input logic [7:0] d);
      logic [ECC_W-1:0] c;
      c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
      c[0] = c[2] ^ c[4] ^ c[6] ^ c[8] ^ c[10];
      c[1] = c[2] ^ c[5] ^ c[6] ^ c[9] ^ c[10];
      c[3] = c[4] ^ c[5] ^ c[6] ^ c[11];
      c[7] = c[8] ^ c[9] ^ c[10] ^ c[11];
      return c;
   endfunction
   function automatic logic [3:0] ecc_syn(input logic [ECC_W-1:0] c);
      logic [3:0] s;
      s = '0;
      for (int i = 0; i < ECC_W; i++) begin
         s = s ^ (c[i] ? 4'(i + 1) : 4'h0);
      end
      return s;
   endfunction
   function automatic logic [7:0] ecc_dec(input logic [ECC_W-1:0] c);
      logic [ECC_W-1:0] f;
      logic [3:0]       s;
      f = c;
      s = ecc_syn(c);
      if (s != 4'h0 && s <= 4'(ECC_W)) begin
         f[s-4'h1] = ~f[s-4'h1];
      end
      return {f[11:8], f[6:4], f[2]};
   endfunction
   function automatic logic [3:0] sector_of(input logic [1:0] bk, input logic [11:0] o);
      logic [3:0] n;
      n = 4'h0;
      if (bk != DATA_BANK) begin
         if (o >= CB_S2_BASE) n = 4'h2;
         else if (o >= CB_S1_BASE) n = 4'h1;
      end else begin
         if (o >= DB_S9_BASE) n = 4'h9;
         else if (o >= DB_S8_BASE) n = 4'h8;
         else if (o >= DB_S7_BASE) n = 4'h7;
         else if (o >= DB_S6_BASE) n = 4'h6;
         else if (o >= DB_S5_BASE) n = 4'h5;
         else if (o >= DB_S4_BASE) n = 4'h4;
         else if (o >= DB_S3_BASE) n = 4'h3;
         else if (o >= DB_S2_BASE) n = 4'h2;
         else if (o >= DB_S1_BASE) n = 4'h1;
      end
      return n;
   endfunction
   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [1:0]  lim;
      logic [11:0] off;
      logic [7:0]  old;
      s_nxt  = s_r;
      lim    = (cmd.addr[ADDR_W-1 -: 2] == DATA_BANK) ? DB_PROG_MAX : CB_PROG_MAX;
      off    = s_r.timer[11:0];
      old    = ecc_dec(mem[{s_r.wl, s_r.timer[4:0]}]);
      mem_we = 1'b0;
      mem_wa = '0;
      mem_wd = '0;
      cnt_we = 1'b0;
      cnt_wa = s_r.wl;
      cnt_wd = 2'h0;
      {s_nxt.out.done, s_nxt.out.aborted, s_nxt.out.reject,
       s_nxt.out.rd_valid, s_nxt.out.nmi_mem, s_nxt.out.nmi_ecc} = 6'h0;
      // reads run beside program/erase in their own counter
      if (s_r.rd_busy) begin
         if (s_r.rd_cnt == '0) begin
            s_nxt.rd_busy       = 1'b0;
            s_nxt.out.rd_valid  = 1'b1;
            s_nxt.out.rd_data   = ecc_dec(s_r.rd_word);
            s_nxt.out.corrected = ecc_syn(s_r.rd_word) != 4'h0;
            s_nxt.out.nmi_ecc = correction_event_nmi_enable && s_nxt.out.corrected;
         end else begin
            s_nxt.rd_cnt = s_r.rd_cnt - 1'b1;
         end
      end else if (rd_req) begin
         s_nxt.rd_busy = 1'b1;
         s_nxt.rd_cnt  = RCNT_W'(READ_CYCLES - 2);
         s_nxt.rd_word = mem[rd_addr];
      end
      case (s_r.st)
         FPE_ST_IDLE: begin
            if (cmd_valid) begin
               s_nxt.bank = cmd.addr[ADDR_W-1 -: 2];
               s_nxt.wl   = cmd.addr[ADDR_W-1:5];
               s_nxt.mask = cmd.sect_mask;
               s_nxt.timer = '0;
               if (cmd.op == FPE_OP_PROG && wl_cnt[cmd.addr[ADDR_W-1:5]] < lim) begin
                  s_nxt.st     = FPE_ST_LOAD;
                  s_nxt.ld_idx = '0;
               end else if (cmd.op == FPE_OP_ERASE && cmd.sect_mask != '0) begin
                  s_nxt.st = FPE_ST_ERASE;
               end else begin
                  s_nxt.out.reject = 1'b1;
               end
            end
         end
         FPE_ST_LOAD: begin
            if (ld_valid) begin
               s_nxt.ld_idx = s_r.ld_idx + 1'b1;
               if (s_r.ld_idx[4:0] == WL_LAST_BYTE) begin
                  s_nxt.st = FPE_ST_PROG;
               end
            end
         end
         FPE_ST_PROG: begin
            s_nxt.timer = s_r.timer + 1'b1;
            if (s_r.timer < TIMER_W'(WL_BYTES)) begin
               // or-in keeps earlier data; second pass adds zeros there
               mem_we = 1'b1;
               mem_wa = {s_r.wl, s_r.timer[4:0]};
               mem_wd = ecc_enc(old | wl_buf[s_r.timer[4:0]]);
            end
            if (s_r.timer == '0) begin
               cnt_we = 1'b1;
               cnt_wd = wl_cnt[s_r.wl] + 1'b1;
            end
            if (s_r.timer == TIMER_W'(PROG_CYCLES - 1)) begin
               s_nxt.st       = FPE_ST_IDLE;
               s_nxt.out.done = 1'b1;
               s_nxt.out.nmi_mem = memory_event_nmi_enable;
            end
         end
         FPE_ST_ERASE: begin
            s_nxt.timer = s_r.timer + 1'b1;
            // clear walk over the bank; an abort leaves sectors half erased
            if (s_r.timer < TIMER_W'(BANK_BYTES) &&
                s_r.mask[sector_of(s_r.bank, off)]) begin
               mem_we = 1'b1;
               mem_wa = {s_r.bank, off};
               cnt_we = off[4:0] == 5'h0;
               cnt_wa = {s_r.bank, off[11:5]};
            end
            // abort wins over the normal end in the same cycle
            if (abort_req || s_r.timer == TIMER_W'(ERASE_CYCLES - 1)) begin
               s_nxt.st          = FPE_ST_IDLE;
               s_nxt.out.done    = 1'b1;
               s_nxt.out.aborted = abort_req;
               s_nxt.out.nmi_mem = memory_event_nmi_enable;
            end
         end
         default: begin
            s_nxt.st = FPE_ST_IDLE;
         end
      endcase
      if (cmd_valid && s_r.st != FPE_ST_IDLE) begin
         s_nxt.out.reject = 1'b1;
      end
      s_nxt.out.busy = s_nxt.st != FPE_ST_IDLE;
   end
   // ----------------------------------------------------------------
   // registers and storage
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
      if (cnt_we) begin
         wl_cnt[cnt_wa] <= cnt_wd;
      end
      if (s_r.st == FPE_ST_LOAD && ld_valid) begin
         wl_buf[s_r.ld_idx[4:0]] <= ld_data;
      end
   end
   assign stat = s_r.out;
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_read_lat;
      rd_req && !s_r.rd_busy |-> ##RD_LAT stat.rd_valid;
   endproperty
   a_read_lat: assert property (p_read_lat) else $error("read latency wrong");
   property p_prog_end;
      s_r.st == FPE_ST_PROG && s_r.timer == TIMER_W'(PROG_CYCLES - 1) |=> stat.done && !stat.busy;
   endproperty
   a_prog_end: assert property (p_prog_end) else $error("program end wrong");
   property p_prog_hold;
      s_r.st == FPE_ST_PROG && s_r.timer != TIMER_W'(PROG_CYCLES - 1)
         |=> s_r.st == FPE_ST_PROG && stat.busy && !stat.done;
   endproperty
   a_prog_hold: assert property (p_prog_hold) else $error("program ended early");
   property p_erase_end;
      s_r.st == FPE_ST_ERASE && !abort_req && s_r.timer == TIMER_W'(ERASE_CYCLES - 1)
         |=> stat.done && !stat.aborted && s_r.st == FPE_ST_IDLE;
   endproperty
   a_erase_end: assert property (p_erase_end) else $error("erase end wrong");
   property p_abort;
      s_r.st == FPE_ST_ERASE && abort_req |=> stat.aborted && stat.done && !stat.busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort not honoured");
   property p_erased_zero;
      mem_we && s_r.st == FPE_ST_ERASE |-> mem_wd == '0;
   endproperty
   a_erased_zero: assert property (p_erased_zero) else $error("erase wrote ones");
   property p_busy_reject;
      cmd_valid && s_r.st != FPE_ST_IDLE |=> stat.reject && stat.busy;
   endproperty
   a_busy_reject: assert property (p_busy_reject) else $error("busy request taken");
   property p_load_start;
      s_r.st == FPE_ST_LOAD && ld_valid && s_r.ld_idx[4:0] == WL_LAST_BYTE
         |=> s_r.st == FPE_ST_PROG && s_r.timer == '0;
   endproperty
   a_load_start: assert property (p_load_start) else $error("program start wrong");
   property p_code_once;
      s_r.st == FPE_ST_IDLE && cmd_valid && cmd.op == FPE_OP_PROG &&
      cmd.addr[ADDR_W-1 -: 2] != DATA_BANK && wl_cnt[cmd.addr[ADDR_W-1:5]] != 2'h0
         |=> stat.reject && s_r.st == FPE_ST_IDLE;
   endproperty
   a_code_once: assert property (p_code_once) else $error("code wordline reprogrammed");
   property p_ecc_nmi;
      stat.nmi_ecc |-> stat.rd_valid && stat.corrected && $past(correction_event_nmi_enable);
   endproperty
   a_ecc_nmi: assert property (p_ecc_nmi) else $error("ecc nmi unfounded");
   c_prog:  cover property (s_r.st == FPE_ST_PROG ##1 s_r.st == FPE_ST_IDLE);
   c_abort: cover property (stat.aborted);
   c_read:  cover property (stat.rd_valid && s_r.st != FPE_ST_IDLE);
   c_rej:   cover property (stat.reject);
endmodule

// file: tb/fpe_cpu_model.sv
`timescale 1ns/1ns
module fpe_cpu_model (
   input  wire logic               core_clk,
   input  wire fpe_pkg::fpe_stat_t stat,
   output logic                    cmd_valid,
   output fpe_pkg::fpe_cmd_t       cmd,
   output logic                    ld_valid,
   output logic [7:0]              ld_data,
   output logic                    abort_req,
   output logic                    rd_req,
   output logic [13:0]             rd_addr
);
   import fpe_pkg::*;

   initial begin
      cmd_valid = 1'b0;
      cmd       = '0;
      ld_valid  = 1'b0;
      ld_data   = 8'h00;
      abort_req = 1'b0;
      rd_req    = 1'b0;
      rd_addr   = '0;
   end

   // ----------------------------------------------------------------
   // requests, launched at falling edges
   // ----------------------------------------------------------------
   // released buses show the inverse so stale values cannot pass
   task automatic send_cmd(input fpe_op_t op, input logic [13:0] a, input logic [9:0] m,
                           output logic rej, output logic bsy);
      @(negedge core_clk);
      cmd_valid = 1'b1;
      cmd       = '{op, a, m};
      @(negedge core_clk);
      cmd_valid = 1'b0;
      cmd       = fpe_cmd_t'(~cmd);
      rej       = stat.reject;
      bsy       = stat.busy;
   endtask

   // always a full wordline, offsets 0..31 back to back
   task automatic load_wl(input logic [255:0] wl);
      for (int i = 0; i < 32; i++) begin
         @(negedge core_clk);
         ld_valid = 1'b1;
         ld_data  = wl[8*i+:8];
      end
      @(negedge core_clk);
      ld_valid = 1'b0;
      ld_data  = ~ld_data;
   endtask

   task automatic read_byte(input logic [13:0] a, output logic [7:0] d, output int lat);
      @(negedge core_clk);
      rd_req  = 1'b1;
      rd_addr = a;
      @(negedge core_clk);
      rd_req  = 1'b0;
      rd_addr = ~a;
      // the edge that took the request already counts as one
      for (lat = 2; lat < 20; lat++) begin
         @(posedge core_clk);
         #1;
         if (stat.rd_valid === 1'b1) break;
      end
      d = stat.rd_data;
   endtask

   task automatic do_abort(output logic dn, output logic ab);
      @(negedge core_clk);
      abort_req = 1'b1;
      @(negedge core_clk);
      abort_req = 1'b0;
      dn        = stat.done;
      ab        = stat.aborted;
   endtask
endmodule

// file: tb/flash_program_erase_control_tb.sv
`timescale 1ns/1ns
`define FPE_CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module flash_program_erase_control_tb;
   import fpe_pkg::*;
   // shortened counts keep the run small
   localparam int PROG_N  = 64;
   localparam int ERASE_N = 4200;
   localparam int LIMIT   = 20000;

   logic              core_clk;
   logic              nrst;
   logic              cmd_valid;
   fpe_cmd_t          cmd;
   logic              ld_valid;
   logic [7:0]        ld_data;
   logic              abort_req;
   logic              rd_req;
   logic [13:0]       rd_addr;
   logic              mem_en;
   logic              ecc_en;
   fpe_stat_t         stat;
   int                n_mismatch = 0;
   int                checked    = 0;
   int                cyc_cnt    = 0;

   fpe_ctrl #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) u_dut (
      .core_clk(core_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd(cmd),
      .ld_valid(ld_valid), .ld_data(ld_data), .abort_req(abort_req), .rd_req(rd_req),
      .rd_addr(rd_addr), .memory_event_nmi_enable(mem_en),
      .correction_event_nmi_enable(ecc_en), .stat(stat));

   fpe_cpu_model u_cpu (
      .core_clk(core_clk), .stat(stat), .cmd_valid(cmd_valid), .cmd(cmd),
      .ld_valid(ld_valid), .ld_data(ld_data), .abort_req(abort_req), .rd_req(rd_req),
      .rd_addr(rd_addr));

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc_cnt++;
      if (cyc_cnt == LIMIT) begin
         n_mismatch++;
         wrap_up();
      end
   end

   function automatic logic [255:0] pat(input logic [7:0] s);
      for (int i = 0; i < 32; i++) pat[8*i+:8] = s ^ 8'(i);
   endfunction

   task automatic wait_done(output logic nmi, output logic ab);
      for (int i = 0; i < 9000; i++) begin
         @(posedge core_clk);
         #1;
         if (stat.done === 1'b1) break;
      end
      nmi = stat.nmi_mem;
      ab  = stat.aborted;
   endtask

   task automatic rd_chk(input logic [13:0] a, input logic [7:0] e);
      logic [7:0] d;
      int         lat;
      u_cpu.read_byte(a, d, lat);
      `FPE_CHK(lat, READ_CYCLES)
      `FPE_CHK({stat.corrected, d}, {1'b0, e})
      `FPE_CHK(stat.nmi_ecc, 1'b0)
   endtask

   task automatic prog_full(input logic [13:0] a, input logic [255:0] wl, output logic rej,
                            output int dur, output logic nmi);
      logic ab;
      logic bsy;
      int   t0;
      dur = 0;
      nmi = 1'b0;
      u_cpu.send_cmd(FPE_OP_PROG, a, '0, rej, bsy);
      if (rej !== 1'b0) return;
      u_cpu.load_wl(wl);
      t0 = cyc_cnt;
      wait_done(nmi, ab);
      dur = cyc_cnt - t0;
   endtask

   task automatic erase_full(input logic [13:0] a, input logic [9:0] m, output logic rej,
                             output int dur);
      logic nmi;
      logic ab;
      logic bsy;
      int   t0;
      dur = 0;
      u_cpu.send_cmd(FPE_OP_ERASE, a, m, rej, bsy);
      if (rej !== 1'b0) return;
      t0 = cyc_cnt;
      wait_done(nmi, ab);
      dur = cyc_cnt - t0;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_code();
      logic rej;
      logic bsy;
      logic nmi;
      logic ab;
      int   t0;
      @(negedge core_clk);
      mem_en = 1'b1;
      u_cpu.send_cmd(FPE_OP_PROG, 14'h1000, '0, rej, bsy);
      `FPE_CHK({rej, bsy}, 2'b01)
      u_cpu.send_cmd(FPE_OP_ERASE, 14'h1000, 10'h001, rej, bsy);
      `FPE_CHK(rej, 1'b1)
      u_cpu.load_wl(pat(8'hA0));
      t0 = cyc_cnt;
      rd_chk(14'h2000, 8'h00);
      `FPE_CHK(stat.busy, 1'b1)
      wait_done(nmi, ab);
      `FPE_CHK(cyc_cnt - t0, PROG_N)
      `FPE_CHK({nmi, stat.busy}, 2'b10)
      rd_chk(14'h1000, 8'hA0);
      rd_chk(14'h101F, 8'hBF);
      prog_full(14'h1000, pat(8'hC0), rej, t0, nmi);
      `FPE_CHK(rej, 1'b1)
      @(negedge core_clk);
      mem_en = 1'b0;
      prog_full(14'h1F00, pat(8'hC0), rej, t0, nmi);
      `FPE_CHK({rej, nmi}, 2'b00)
   endtask

   task automatic t_erase();
      logic rej;
      logic nmi;
      int   dur;
      erase_full(14'h1000, 10'h000, rej, dur);
      `FPE_CHK(rej, 1'b1)
      erase_full(14'h1000, 10'h001, rej, dur);
      `FPE_CHK({rej, dur}, {1'b0, ERASE_N})
      rd_chk(14'h1000, 8'h00);
      rd_chk(14'h1F00, 8'hC0);
      prog_full(14'h1000, pat(8'h90), rej, dur, nmi);
      `FPE_CHK({rej, dur}, {1'b0, PROG_N})
      rd_chk(14'h1001, 8'h91);
   endtask

   task automatic t_data();
      logic [255:0] w;
      logic [255:0] lo_half;
      logic [255:0] hi_half;
      logic         rej;
      logic         nmi;
      int           dur;
      w       = pat(8'h50);
      lo_half = {128'h0, w[127:0]};
      w       = pat(8'h60);
      hi_half = {w[255:128], 128'h0};
      prog_full(14'h0F60, pat(8'h70), rej, dur, nmi);
      prog_full(14'h0F80, lo_half, rej, dur, nmi);
      `FPE_CHK(rej, 1'b0)
      prog_full(14'h0F80, hi_half, rej, dur, nmi);
      `FPE_CHK(rej, 1'b0)
      prog_full(14'h0F80, hi_half, rej, dur, nmi);
      `FPE_CHK(rej, 1'b1)
      rd_chk(14'h0F80, 8'h50);
      rd_chk(14'h0F9F, 8'h7F);
      erase_full(14'h0F80, 10'h200, rej, dur);
      `FPE_CHK(rej, 1'b0)
      rd_chk(14'h0F9F, 8'h00);
      rd_chk(14'h0F7F, 8'h6F);
   endtask

   task automatic t_abort();
      logic rej;
      logic bsy;
      logic dn;
      logic ab;
      u_cpu.send_cmd(FPE_OP_ERASE, 14'h0000, 10'h3FF, rej, bsy);
      `FPE_CHK(rej, 1'b0)
      repeat (20) @(negedge core_clk);
      u_cpu.do_abort(dn, ab);
      `FPE_CHK({dn, ab, stat.busy}, 3'b110)
   endtask

   initial begin
      nrst   = 1'b0;
      mem_en = 1'b0;
      ecc_en = 1'b0;
      repeat (20) @(posedge core_clk);
      @(negedge core_clk);
      `FPE_CHK(stat, fpe_stat_t'('0))
      nrst   = 1'b1;
      ecc_en = 1'b1;
      rd_chk(14'h0000, 8'h00);
      rd_chk(14'h3FFF, 8'h00);
      t_code();
      t_erase();
      t_data();
      t_abort();
      wrap_up();
   end
endmodule
